// File: verilog/cpmsc_top.sv
// Capture and PWM mode, sync and counter control with APB registers.
`timescale 1ns/100ps
`default_nettype none

`include "cpmsc_map.svh"

// Contract
// - In PWM mode a clear polarity bit makes the output high while counting below compare, a set bit inverts it.
// - With the mode bit clear the module captures, the pin is an input and capture loads may be enabled.
// - In capture mode the period event neither resets the counter nor moves shadows into registers one and two.
// - With the mode bit set the pin is the PWM output and no time-stamp reaches any capture register.
// - In PWM mode the period event resets the counter so each period starts again.
// - In PWM mode registers one and two load from their shadows on the period event.
// - Writing one to the software sync bit loads this counter when sync-in is enabled and goes downstream when sync-out select is 00.
// - Writing zero to the software sync bit does nothing and the bit always reads zero.
// - Sync-out passes sync-in on 00, the period event on 01, and nothing on 10 or 11.
// - The period event selection for sync-out also works in capture mode.
// - With sync-in enabled a sync-in pulse or software sync loads the counter from the phase register.
// - The counter stands still while the freeze bit is clear and runs while it is set.
// - In PWM mode register three shadows the period and register four shadows the compare value.
module cpmsc_top (
  // Clock and reset.
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  // APB slave.
  input  wire cpmsc_pkg::cpmsc_apb_req_s apbReq,
  output cpmsc_pkg::cpmsc_apb_rsp_s      apbRsp,
  // Capture sequencer strobes, one per capture register.
  input  wire logic [3:0]                captureLoad,
  // Sync daisy chain.
  input  wire logic                      syncInPulse,
  output logic                           syncOut,
  // Capture or PWM pin.
  input  wire logic                      capPinIn,
  output logic                           captureInSync,
  output logic                           pwmOut,
  output logic                           pwmOe_n
);

  // ****************************************************************
  // State and decode helpers.
  // ****************************************************************
  cpmsc_pkg::cpmsc_state_s st;
  cpmsc_pkg::cpmsc_state_s next_st;

  logic                   setup;
  logic                   access;
  logic                   pwmMode;
  logic                   periodEvent;
  logic                   syncLoad;
  cpmsc_pkg::cpmsc_word_t readWord;
  cpmsc_pkg::cpmsc_word_t ctrlWord;

  // Tells whether an address selects a register.
  function automatic logic isMapped(input logic [7:0] addr);
    isMapped = (addr == `CPMSC_OFS_CTRL) || (addr == `CPMSC_OFS_CNT) ||
               (addr == `CPMSC_OFS_PHS) || (addr == `CPMSC_OFS_CAPTURE_REGISTER_ONE) ||
               (addr == `CPMSC_OFS_CAPTURE_REGISTER_TWO) || (addr == `CPMSC_OFS_CAPTURE_REGISTER_THREE) ||
               (addr == `CPMSC_OFS_CAPTURE_REGISTER_FOUR);
  endfunction

  // Gives the capture register index for an address.
  function automatic logic [1:0] capIndex(input logic [7:0] addr);
    logic [7:0] delta;
    delta = addr - `CPMSC_OFS_CAPTURE_REGISTER_ONE;
    capIndex = delta[3:2];
  endfunction

  // Tells whether an address selects a capture register.
  function automatic logic isCap(input logic [7:0] addr);
    isCap = (addr >= `CPMSC_OFS_CAPTURE_REGISTER_ONE) && (addr <= `CPMSC_OFS_CAPTURE_REGISTER_FOUR) &&
            (addr[1:0] == 2'h0);
  endfunction

  assign setup = apbReq.psel & ~apbReq.penable;
  assign access = apbReq.psel & apbReq.penable & st.rsp.pready;
  assign pwmMode = st.ctrl.captureOrPwmSelect;

  // ****************************************************************
  // Period event and sync load.
  // ****************************************************************
  // The counter equals the period held in capture register one.
  assign periodEvent = st.ctrl.counterFreezeControl &
                       (st.timeStampCounter == st.cap[0]);

  // A sync pulse or the software strobe loads the phase when enabled.
  assign syncLoad = st.ctrl.syncInEnable &
                    (syncInPulse | st.softwareSyncStrobe);

  // ****************************************************************
  // Read data.
  // ****************************************************************
  always_comb begin
    ctrlWord = `CPMSC_WORD_RST;
    ctrlWord[`CPMSC_BIT_POL] = st.ctrl.pwmOutputPolarity;
    ctrlWord[`CPMSC_BIT_MODE] = st.ctrl.captureOrPwmSelect;
    ctrlWord[`CPMSC_BIT_SOFTWARE_SYNC_STROBE] = 1'b0;
    ctrlWord[`CPMSC_BIT_SEL_HI:`CPMSC_BIT_SEL_LO] = st.ctrl.syncOutSourceSelect;
    ctrlWord[`CPMSC_BIT_SYNCEN] = st.ctrl.syncInEnable;
    ctrlWord[`CPMSC_BIT_RUN] = st.ctrl.counterFreezeControl;
  end

  always_comb begin
    readWord = `CPMSC_WORD_RST;
    if (isCap(apbReq.paddr)) begin
      readWord = st.cap[capIndex(apbReq.paddr)];
    end else begin
      case (apbReq.paddr)
        `CPMSC_OFS_CTRL: begin
          readWord = ctrlWord;
        end
        `CPMSC_OFS_CNT: begin
          readWord = st.timeStampCounter;
        end
        `CPMSC_OFS_PHS: begin
          readWord = st.counterPhaseValue;
        end
        default: begin
          readWord = `CPMSC_WORD_RST;
        end
      endcase
    end
  end

  // ****************************************************************
  // Next state.
  // ****************************************************************
  always_comb begin
    next_st = st;

    // APB answer: no wait state, ready in the first access cycle.
    next_st.rsp.pready = setup;
    next_st.rsp.pslverr = setup & ~isMapped(apbReq.paddr);
    if (setup) begin
      next_st.rsp.prdata = apbReq.pwrite ? `CPMSC_WORD_RST : readWord;
    end

    // The software strobe lasts one cycle and then clears itself.
    next_st.softwareSyncStrobe = 1'b0;

    // Pin synchroniser, then gated by the mode.
    next_st.capPinMeta = capPinIn;
    next_st.capPinSafe = st.capPinMeta;
    next_st.captureInSync = st.capPinSafe & ~pwmMode;

    // Time-stamp counter.
    if (syncLoad) begin
      next_st.timeStampCounter = st.counterPhaseValue;
    end else if (periodEvent && pwmMode) begin
      next_st.timeStampCounter = `CPMSC_WORD_RST;
    end else if (st.ctrl.counterFreezeControl) begin
      next_st.timeStampCounter = st.timeStampCounter + 32'h0000_0001;
    end

    // Time-stamp loads only in capture mode.
    for (int i = 0; i < 4; i++) begin
      if (captureLoad[i] && !pwmMode) begin
        next_st.cap[i] = st.timeStampCounter;
      end
    end

    // Shadow transfer on the period boundary only in PWM mode.
    if (periodEvent && pwmMode) begin
      next_st.cap[0] = st.cap[2];
      next_st.cap[1] = st.cap[3];
    end

    // Register writes take effect at the access edge.
    if (access && apbReq.pwrite) begin
      if (isCap(apbReq.paddr)) begin
        next_st.cap[capIndex(apbReq.paddr)] = apbReq.pwdata;
      end else begin
        case (apbReq.paddr)
          `CPMSC_OFS_CTRL: begin
            next_st.ctrl.pwmOutputPolarity = apbReq.pwdata[`CPMSC_BIT_POL];
            next_st.ctrl.captureOrPwmSelect = apbReq.pwdata[`CPMSC_BIT_MODE];
            next_st.ctrl.syncOutSourceSelect =
              apbReq.pwdata[`CPMSC_BIT_SEL_HI:`CPMSC_BIT_SEL_LO];
            next_st.ctrl.syncInEnable = apbReq.pwdata[`CPMSC_BIT_SYNCEN];
            next_st.ctrl.counterFreezeControl = apbReq.pwdata[`CPMSC_BIT_RUN];
            next_st.softwareSyncStrobe = apbReq.pwdata[`CPMSC_BIT_SOFTWARE_SYNC_STROBE];
          end
          `CPMSC_OFS_CNT: begin
            next_st.timeStampCounter = apbReq.pwdata;
          end
          `CPMSC_OFS_PHS: begin
            next_st.counterPhaseValue = apbReq.pwdata;
          end
          default: begin
            next_st.counterPhaseValue = st.counterPhaseValue;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= '0;
      st.ctrl <= cpmsc_pkg::cpmsc_ctrl_s'(`CPMSC_CTRL_RST);
      st.timeStampCounter <= `CPMSC_WORD_RST;
      st.counterPhaseValue <= `CPMSC_WORD_RST;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // PWM output and sync chain.
  // ****************************************************************
  cpmsc_pwm_out pwmStage (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .counter  (st.timeStampCounter),
    .compare  (st.cap[1]),
    .pwmMode  (pwmMode),
    .polarity (st.ctrl.pwmOutputPolarity),
    .pwmOut   (pwmOut),
    .pwmOe_n  (pwmOe_n)
  );

  cpmsc_sync_route syncStage (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .syncInPulse  (syncInPulse),
    .softwareSync (st.softwareSyncStrobe),
    .periodEvent  (periodEvent),
    .select       (st.ctrl.syncOutSourceSelect),
    .syncOut      (syncOut)
  );

  assign apbRsp = st.rsp;
  assign captureInSync = st.captureInSync;

endmodule
`default_nettype wire

// File: shared/cpmsc_map.svh
// Register offsets, field positions, codes and reset values of the capture and PWM control block.
`ifndef CPMSC_MAP_SVH
`define CPMSC_MAP_SVH

// ****************************************************************
// Register byte offsets on the APB.
// ****************************************************************
`define CPMSC_OFS_CTRL 8'h00
`define CPMSC_OFS_CNT 8'h04
`define CPMSC_OFS_PHS 8'h08
`define CPMSC_OFS_CAPTURE_REGISTER_ONE 8'h0C
`define CPMSC_OFS_CAPTURE_REGISTER_TWO 8'h10
`define CPMSC_OFS_CAPTURE_REGISTER_THREE 8'h14
`define CPMSC_OFS_CAPTURE_REGISTER_FOUR 8'h18

// ****************************************************************
// Field positions in capture_control_two.
// ****************************************************************
`define CPMSC_BIT_RUN 4
`define CPMSC_BIT_SYNCEN 5
`define CPMSC_BIT_SEL_LO 6
`define CPMSC_BIT_SEL_HI 7
`define CPMSC_BIT_SOFTWARE_SYNC_STROBE 8
`define CPMSC_BIT_MODE 9
`define CPMSC_BIT_POL 10

// ****************************************************************
// Sync-out source select codes.
// ****************************************************************
`define CPMSC_SEL_PASS 2'h0
`define CPMSC_SEL_PRD 2'h1

// ****************************************************************
// Reset values.
// ****************************************************************
`define CPMSC_CTRL_RST 6'h00
`define CPMSC_WORD_RST 32'h0000_0000

`endif

// File: shared/cpmsc_pkg.sv
// Types shared by the capture and PWM control block.
package cpmsc_pkg;

  typedef logic [31:0] cpmsc_word_t;

  // APB request from the master.
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    cpmsc_word_t pwdata;
  } cpmsc_apb_req_s;

  // APB answer to the master.
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    cpmsc_word_t prdata;
  } cpmsc_apb_rsp_s;

  // Stored control fields of capture_control_two.
  typedef struct packed {
    logic       pwmOutputPolarity;
    logic       captureOrPwmSelect;
    logic [1:0] syncOutSourceSelect;
    logic       syncInEnable;
    logic       counterFreezeControl;
  } cpmsc_ctrl_s;

  // Whole state of the main module.
  typedef struct packed {
    cpmsc_ctrl_s           ctrl;
    logic                  softwareSyncStrobe;
    cpmsc_word_t           timeStampCounter;
    cpmsc_word_t           counterPhaseValue;
    logic [3:0][31:0]      cap;
    cpmsc_apb_rsp_s        rsp;
    logic                  capPinMeta;
    logic                  capPinSafe;
    logic                  captureInSync;
  } cpmsc_state_s;

  // State of the PWM output stage.
  typedef struct packed {
    logic pwmOut;
    logic pwmOe_n;
  } cpmsc_pwm_s;

  // State of the sync-out router.
  typedef struct packed {
    logic syncOut;
  } cpmsc_sync_s;

endpackage

// File: verilog/cpmsc_pwm_out.sv
// PWM output stage: compares the counter with the active compare value.
`timescale 1ns/100ps
`default_nettype none

module cpmsc_pwm_out (
  // Clock and reset.
  input  wire logic               ref_clk,
  input  wire logic               rst,
  // Timing inputs.
  input  wire cpmsc_pkg::cpmsc_word_t counter,
  input  wire cpmsc_pkg::cpmsc_word_t compare,
  // Control.
  input  wire logic               pwmMode,
  input  wire logic               polarity,
  // Pin.
  output logic                    pwmOut,
  output logic                    pwmOe_n
);

  cpmsc_pkg::cpmsc_pwm_s st;
  cpmsc_pkg::cpmsc_pwm_s next_st;

  // ****************************************************************
  // Next state.
  // ****************************************************************
  always_comb begin
    next_st = st;
    next_st.pwmOe_n = ~pwmMode;
    if (pwmMode) begin
      next_st.pwmOut = (counter < compare) ^ polarity;
    end else begin
      next_st.pwmOut = 1'b0;
    end
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= '{pwmOut: 1'b0, pwmOe_n: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign pwmOut = st.pwmOut;
  assign pwmOe_n = st.pwmOe_n;

endmodule
`default_nettype wire

// File: verilog/cpmsc_sync_route.sv
// Sync-out router for the daisy chain of neighbouring modules.
`timescale 1ns/100ps
`default_nettype none

`include "cpmsc_map.svh"

module cpmsc_sync_route (
  // Clock and reset.
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Event sources.
  input  wire logic       syncInPulse,
  input  wire logic       softwareSync,
  input  wire logic       periodEvent,
  input  wire logic [1:0] select,
  // Chain output.
  output logic            syncOut
);

  cpmsc_pkg::cpmsc_sync_s st;
  cpmsc_pkg::cpmsc_sync_s next_st;

  // ****************************************************************
  // Next state.
  // ****************************************************************
  always_comb begin
    next_st = st;
    case (select)
      `CPMSC_SEL_PASS: begin
        next_st.syncOut = syncInPulse | softwareSync;
      end
      `CPMSC_SEL_PRD: begin
        next_st.syncOut = periodEvent;
      end
      default: begin
        next_st.syncOut = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= '{syncOut: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign syncOut = st.syncOut;

endmodule
`default_nettype wire

// File: tb/cpmsc_chain_model.sv
// Neighbouring modules on the sync daisy chain, upstream and downstream.
`timescale 1ns/100ps
`default_nettype none
module cpmsc_chain_model (
  // Clock and reset.
  input  wire logic  ref_clk,
  input  wire logic  rst,
  // Bench request and chain signals.
  input  wire logic  fire,
  input  wire logic  syncOut,
  output logic       syncInPulse,
  output logic [7:0] seen
);
  // Upstream sends a one-cycle pulse; downstream counts arriving pulses.
  always_ff @(posedge ref_clk) begin
    syncInPulse <= fire & ~rst;
    if (rst) begin
      seen <= 8'h00;
    end else if (syncOut) begin
      seen <= seen + 8'h01;
    end
  end
endmodule
`default_nettype wire

// File: tb/cpmsc_top_asserts.sv
// Concurrent checks on the ports of the capture and PWM control block.
`timescale 1ns/100ps
`default_nettype none
module cpmsc_top_asserts (
  // Clock and reset.
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  // Bus.
  input  wire cpmsc_pkg::cpmsc_apb_req_s apbReq,
  input  wire cpmsc_pkg::cpmsc_apb_rsp_s apbRsp,
  // Chain and pin.
  input  wire logic                      syncInPulse,
  input  wire logic                      syncOut,
  input  wire logic                      captureInSync,
  input  wire logic                      pwmOut,
  input  wire logic                      pwmOe_n
);
  // ****************************************
  // Control mirror and checks.
  // ****************************************
  logic [10:4] mirror;
  logic        setup;
  logic        ctrlWr;
  assign setup  = apbReq.psel & ~apbReq.penable;
  assign ctrlWr = apbReq.psel & apbReq.penable & apbRsp.pready & apbReq.pwrite & (apbReq.paddr == 8'h00);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mirror <= 7'h00;
    end else if (ctrlWr) begin
      mirror <= {apbReq.pwdata[10:9], 1'b0, apbReq.pwdata[7:4]};
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_ready_next: assert property (setup |=> apbRsp.pready) else $error("pready missing");
  a_err_unmapped: assert property (setup && apbReq.paddr > 8'h18 |=> apbRsp.pslverr && apbRsp.prdata == 32'h0)
    else $error("unmapped access not refused");
  a_ctrl_readback: assert property (setup && !apbReq.pwrite && apbReq.paddr == 8'h00 |=>
    apbRsp.prdata == {21'h0, mirror, 4'h0}) else $error("control readback wrong");
  a_software_sync_strobe_out: assert property (ctrlWr && apbReq.pwdata[8] && apbReq.pwdata[7:6] == 2'h0 |-> ##2 syncOut)
    else $error("software sync not sent");
  a_sync_pass: assert property (syncInPulse && mirror[7:6] == 2'h0 |=> syncOut) else $error("sync not passed");
  a_sync_off: assert property (mirror[7] |=> !syncOut) else $error("sync out not disabled");
  a_oe_mode: assert property (pwmOe_n == !$past(mirror[9])) else $error("pin direction wrong");
  a_pwm_idle: assert property (pwmOe_n |-> !pwmOut) else $error("pwm active in capture mode");
  a_capsync_off: assert property (!pwmOe_n |-> !captureInSync) else $error("pin input seen in pwm mode");
endmodule
bind cpmsc_top cpmsc_top_asserts u_chk (.ref_clk(ref_clk), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp),
  .syncInPulse(syncInPulse), .syncOut(syncOut), .captureInSync(captureInSync), .pwmOut(pwmOut), .pwmOe_n(pwmOe_n));
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench of the capture and PWM control block.
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct packed {
    logic                   w;
    logic [7:0]             a;
    cpmsc_pkg::cpmsc_word_t d;
    cpmsc_pkg::cpmsc_word_t q;
    logic                   e;
  } cpmsc_row_s;
  logic                      ref_clk = 1'b0;
  logic                      rst = 1'b1;
  cpmsc_pkg::cpmsc_apb_req_s req = '0;
  cpmsc_pkg::cpmsc_apb_rsp_s rsp;
  logic [3:0]                captureLoad = 4'h0;
  logic                      capPinIn = 1'b1;
  logic                      fire = 1'b0;
  logic                      syncInPulse;
  logic                      syncOut;
  logic                      captureInSync;
  logic                      pwmOut;
  logic                      pwmOe_n;
  logic [7:0]                seen;
  cpmsc_pkg::cpmsc_word_t    rq;
  logic                      re;
  int                        nMismatch = 0;
  int                        testsRun = 0;
  int                        ns = 0;
  cpmsc_pkg::cpmsc_word_t    hi;
  cpmsc_row_s rows [10] = '{
    '{1'b0, 8'h00, 32'h0, 32'h0, 1'b0},
    '{1'b0, 8'h04, 32'h0, 32'h0, 1'b0},
    '{1'b1, 8'h08, 32'h1234, 32'h0, 1'b0},
    '{1'b0, 8'h08, 32'h0, 32'h1234, 1'b0},
    '{1'b1, 8'h14, 32'hA5A5A5A5, 32'h0, 1'b0},
    '{1'b0, 8'h14, 32'h0, 32'hA5A5A5A5, 1'b0},
    '{1'b1, 8'h1C, 32'hFF, 32'h0, 1'b1},
    '{1'b0, 8'h1C, 32'h0, 32'h0, 1'b1},
    '{1'b1, 8'h00, 32'h7E0, 32'h0, 1'b0},
    '{1'b0, 8'h00, 32'h0, 32'h6E0, 1'b0}
  };

  cpmsc_top DUT (.ref_clk(ref_clk), .rst(rst), .apbReq(req), .apbRsp(rsp), .captureLoad(captureLoad),
    .syncInPulse(syncInPulse), .syncOut(syncOut), .capPinIn(capPinIn), .captureInSync(captureInSync),
    .pwmOut(pwmOut), .pwmOe_n(pwmOe_n));
  cpmsc_chain_model u_chain (.ref_clk(ref_clk), .rst(rst), .fire(fire), .syncOut(syncOut),
    .syncInPulse(syncInPulse), .seen(seen));

  always #5 ref_clk = ~ref_clk;

  // ****************************************
  // Bus, check and report tasks.
  // ****************************************
  task automatic chk(input string n, input cpmsc_pkg::cpmsc_word_t e, input cpmsc_pkg::cpmsc_word_t g);
    testsRun++;
    if (g !== e) begin
      nMismatch++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input cpmsc_pkg::cpmsc_word_t d);
    @(posedge ref_clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (rsp.pready !== 1'b1);
    rq = rsp.prdata;
    re = rsp.pslverr;
    req <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input cpmsc_pkg::cpmsc_word_t d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input string n, input logic [7:0] a, input cpmsc_pkg::cpmsc_word_t e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rq);
  endtask
  task automatic pulse();
    @(posedge ref_clk);
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic load();
    @(posedge ref_clk);
    captureLoad <= 4'hF;
    @(posedge ref_clk);
    captureLoad <= 4'h0;
  endtask
  task automatic duty(input int e);
    hi = 32'h0;
    repeat (10) @(posedge ref_clk);
    repeat (60) begin
      @(negedge ref_clk);
      hi += 32'(pwmOut);
    end
    chk("pwmHigh", 32'(e), hi);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", testsRun, nMismatch);
    if (nMismatch == 0 && testsRun > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    nMismatch++;
    summarize();
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk("slverr", 32'(rows[i].e), 32'(re));
      if (!rows[i].w) chk("rdata", rows[i].q, rq);
    end
    $display("test registers done");
    wr(8'h00, 32'h0);
    wr(8'h04, 32'hFFFFFFFE);
    wr(8'h00, 32'h10);
    wr(8'h00, 32'h0);
    rd("counterWrap", 8'h04, 32'h1);
    rd("counterFrozen", 8'h04, 32'h1);
    $display("test counter done");
    wr(8'h08, 32'h100);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h20);
    pulse();
    ns++;
    rd("syncInLoad", 8'h04, 32'h100);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h120);
    ns++;
    repeat (2) @(posedge ref_clk);
    rd("softSyncLoad", 8'h04, 32'h100);
    chk("syncOutCount", 32'(ns), 32'(seen));
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0);
    pulse();
    ns++;
    rd("syncInIgnored", 8'h04, 32'h0);
    wr(8'h00, 32'h80);
    pulse();
    wr(8'h00, 32'hC0);
    pulse();
    chk("syncOutBlocked", 32'(ns), 32'(seen));
    wr(8'h0C, 32'h3);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h50);
    repeat (20) @(posedge ref_clk);
    wr(8'h00, 32'h0);
    ns++;
    chk("periodSyncCap", 32'(ns), 32'(seen));
    $display("test sync done");
    wr(8'h0C, 32'h5);
    wr(8'h14, 32'h5);
    wr(8'h10, 32'h2);
    wr(8'h18, 32'h2);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h210);
    duty(20);
    chk("pinDriven", 32'h0, 32'(pwmOe_n));
    wr(8'h00, 32'h610);
    duty(40);
    wr(8'h14, 32'h7);
    repeat (20) @(posedge ref_clk);
    rd("periodShadow", 8'h0C, 32'h7);
    wr(8'h00, 32'h600);
    apb(1'b0, 8'h04, 32'h0);
    chk("periodBound", 32'h1, 32'(rq <= 32'h7));
    $display("test pwm done");
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h55);
    load();
    rd("captureLoad", 8'h10, 32'h55);
    chk("pinInput", 32'h1, 32'(captureInSync));
    capPinIn <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk("pinLow", 32'h0, 32'(captureInSync));
    wr(8'h00, 32'h200);
    wr(8'h04, 32'h66);
    load();
    rd("captureBlocked", 8'h18, 32'h55);
    $display("test capture done");
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    chk("oeReset", 32'h1, 32'(pwmOe_n));
    rd("ctrlReset", 8'h00, 32'h0);
    rd("phaseReset", 8'h08, 32'h0);
    $display("test reset done");
    summarize();
  end
endmodule
`default_nettype wire
